// file: pcicc_regs.svh
// Register offsets, field positions and reset values for the command block
`ifndef PCICC_REGS_SVH
`define PCICC_REGS_SVH

`define PCICC_CMD_OFFSET 8'h04
`define PCICC_CLASS_OFFSET 8'h08
`define PCICC_CMD_RESET 16'h0000
`define PCICC_CMD_WR_MASK 16'h0027
`define PCICC_BIT_IO 0
`define PCICC_BIT_MEM 1
`define PCICC_BIT_MASTER 2
`define PCICC_BIT_SPECIAL 3
`define PCICC_BIT_MWI 4
`define PCICC_BIT_SNOOP 5
`define PCICC_BASE_DISPLAY 8'h03
`define PCICC_BASE_ZERO 8'h00
`define PCICC_SUB_OTHER 8'h80
`define PCICC_SUB_VGA 8'h01
`define PCICC_SUB_NONE 8'h00
`define PCICC_IFACE 8'h00

`endif

// file: pcicc_pkg.sv
// Types shared by the command and class code block
package pcicc_pkg;
  typedef logic [5:0] pcicc_dword_t;
  typedef logic [31:0] pcicc_data_t;
  typedef logic [3:0] pcicc_be_t;
  typedef struct packed {
    logic [15:0] command;
    pcicc_data_t rd_data;
  } pcicc_state_t;
endpackage

// file: pcicc_cfg.sv
// Command register and class code of the configuration header
`timescale 1ns/1ps
`default_nettype none
`include "pcicc_regs.svh"
// Summary of operation
// - All-zero command leaves only configuration access.
// - Bit 0 gates I/O space claiming.
// - Bit 1 gates memory space claiming.
// - Bit 2 gates starting master transactions.
// - Bit 5 enables palette write snooping.
// - Bits 3 and 4 read zero.
// - Bits 6 to 15 read zero.
// - Base class 03h, sub 80h or 01h.
// - Zero base class, sub 00h or 01h.
module pcicc_cfg (
  input wire logic core_clk, // PCI bus clock
  input wire logic rst_b, // PCI reset, active low, asynchronous
  input wire logic zero_base_class_select, // Reset-time config bit
  input wire logic fixed_vga_enable, // Reset-time config bit
  input wire logic cfg_sel, // Configuration cycle aimed here
  input wire logic cfg_wr, // 1 write, 0 read
  input wire pcicc_pkg::pcicc_dword_t cfg_dword, // Dword index
  input wire pcicc_pkg::pcicc_be_t cfg_be, // Byte enables, active high
  input wire pcicc_pkg::pcicc_data_t cfg_wdata, // Write data
  output logic [31:0] cfg_rdata, // Registered read data
  input wire logic io_hit, // I/O address matches this device
  input wire logic mem_hit, // Memory address matches this device
  input wire logic palette_wr, // Palette register write seen
  input wire logic master_req, // Core wants a master transaction
  output logic io_claim, // Claim I/O access
  output logic mem_claim, // Claim memory access
  output logic palette_snoop, // Snoop palette write, do not claim
  output logic master_start, // Master transaction permitted
  output logic special_claim, // Special cycle response, always 0
  output logic mwi_issue, // Write-and-invalidate use, always 0
  output logic [15:0] pci_bus_command, // Current command value
  output logic [23:0] function_class_value // Class code
);
  import pcicc_pkg::*;

  pcicc_state_t q;
  pcicc_state_t next_q;
  logic [1:0] rst_sync;
  logic rst_int_b;
  logic [1:0] strap_meta;
  logic [1:0] strap_sync;
  logic zero_base_sync;
  logic fixed_vga_sync;
  logic [23:0] class_q;
  logic [23:0] next_class;
  logic cfg_rd;
  logic cmd_wr_hit;
  logic cmd_rd_hit;
  logic class_rd_hit;

  // Reset drops at once but lifts only on a clock edge, so no flop
  // leaves reset part way through a cycle
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_int_b = rst_sync[1];

  // Straps are pins, so they pass two stages before the decode sees them.
  // No reset here: the class code must have settled when reset lifts,
  // which holds as long as reset lasts more than three clocks.
  always_ff @(posedge core_clk) begin
    strap_meta <= {zero_base_class_select, fixed_vga_enable};
    strap_sync <= strap_meta;
    class_q <= next_class;
  end
  assign zero_base_sync = strap_sync[1];
  assign fixed_vga_sync = strap_sync[0];

  // True when a dword index lands on the byte offset of a register
  function automatic logic dword_is(input pcicc_dword_t idx,
      input logic [7:0] offset);
    logic [7:0] word;
    word = offset >> 2;
    dword_is = (idx == word[5:0]);
  endfunction

  // Class code from the two straps; the interface byte is always zero
  function automatic logic [23:0] class_decode(input logic zero_base,
      input logic fixed_vga);
    logic [7:0] base;
    logic [7:0] sub;
    if (zero_base) begin
      base = `PCICC_BASE_ZERO;
    end else begin
      base = `PCICC_BASE_DISPLAY;
    end
    if (fixed_vga) begin
      sub = `PCICC_SUB_VGA;
    end else if (zero_base) begin
      sub = `PCICC_SUB_NONE;
    end else begin
      sub = `PCICC_SUB_OTHER;
    end
    class_decode = {base, sub, `PCICC_IFACE};
  endfunction

  // Only writable bits in enabled bytes change; the fixed zero bits
  // are never stored, so they cannot read back as ones
  function automatic logic [15:0] merge_cmd(input logic [15:0] old,
      input logic [31:0] wd, input logic [3:0] be);
    logic [15:0] m;
    m = {{8{be[1]}}, {8{be[0]}}} & `PCICC_CMD_WR_MASK;
    merge_cmd = (old & ~m) | (wd[15:0] & m);
  endfunction

  assign next_class = class_decode(zero_base_sync, fixed_vga_sync);
  assign cfg_rd = cfg_sel && !cfg_wr;
  assign cmd_wr_hit = cfg_sel && cfg_wr &&
    dword_is(cfg_dword, `PCICC_CMD_OFFSET);
  assign cmd_rd_hit = cfg_rd && dword_is(cfg_dword, `PCICC_CMD_OFFSET);
  assign class_rd_hit = cfg_rd &&
    dword_is(cfg_dword, `PCICC_CLASS_OFFSET);

  // Configuration cycles bypass the command gates, so even an all-zero
  // command still answers them
  always_comb begin
    next_q = q;
    if (cmd_wr_hit) begin
      next_q.command =
        merge_cmd(q.command, cfg_wdata, cfg_be);
    end
    if (cmd_rd_hit) begin
      next_q.rd_data = {16'h0000, q.command & `PCICC_CMD_WR_MASK};
    end else if (class_rd_hit) begin
      next_q.rd_data = {class_q, 8'h00};
    end else if (cfg_rd) begin
      next_q.rd_data = 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      q.command <= `PCICC_CMD_RESET;
      q.rd_data <= 32'h0000_0000;
    end else begin
      q <= next_q;
    end
  end

  assign cfg_rdata = q.rd_data;
  assign pci_bus_command = q.command;
  assign function_class_value = class_q;
  // Claims are plain gates, so a command write acts on the next cycle
  assign io_claim = io_hit && q.command[`PCICC_BIT_IO];
  assign mem_claim = mem_hit && q.command[`PCICC_BIT_MEM];
  assign master_start = master_req && q.command[`PCICC_BIT_MASTER];
  assign palette_snoop = palette_wr && q.command[`PCICC_BIT_SNOOP];
  assign special_claim = 1'b0;
  assign mwi_issue = 1'b0;

  a_io_gate: assert property (
    @(posedge core_clk) disable iff (!rst_int_b)
    io_claim |-> pci_bus_command[0])
    else $error("io claimed while off");
  a_io_claim: assert property (
    @(posedge core_clk) disable iff (!rst_int_b)
    io_hit && pci_bus_command[0] |-> io_claim)
    else $error("io access not claimed");
  a_mem_gate: assert property (
    @(posedge core_clk) disable iff (!rst_int_b)
    mem_claim |-> pci_bus_command[1])
    else $error("mem claimed while off");
  a_mem_claim: assert property (
    @(posedge core_clk) disable iff (!rst_int_b)
    mem_hit && pci_bus_command[1] |-> mem_claim)
    else $error("mem access not claimed");
  a_master_gate: assert property (
    @(posedge core_clk) disable iff (!rst_int_b)
    master_start |-> pci_bus_command[2])
    else $error("master while off");
  a_master_allow: assert property (
    @(posedge core_clk) disable iff (!rst_int_b)
    master_req && pci_bus_command[2] |-> master_start)
    else $error("master blocked while on");
  a_snoop_gate: assert property (
    @(posedge core_clk) disable iff (!rst_int_b)
    palette_wr && pci_bus_command[5] |-> palette_snoop)
    else $error("snoop missed");
  a_snoop_only: assert property (
    @(posedge core_clk) disable iff (!rst_int_b)
    palette_snoop |-> pci_bus_command[5])
    else $error("snoop while off");
  a_ro_bits: assert property (
    @(posedge core_clk) disable iff (!rst_int_b)
    pci_bus_command[15:6] == 10'h000 && pci_bus_command[4:3] == 2'h0)
    else $error("read-only bit set");
  a_fixed_low: assert property (
    @(posedge core_clk) disable iff (!rst_int_b)
    !special_claim && !mwi_issue)
    else $error("unsupported cycle used");
  a_zero_cmd: assert property (
    @(posedge core_clk) disable iff (!rst_int_b)
    pci_bus_command == 16'h0000 |-> !io_claim && !mem_claim && !master_start)
    else $error("active with zero command");
  a_class_disp: assert property (
    @(posedge core_clk) disable iff (!rst_int_b)
    !zero_base_class_select |-> function_class_value ==
    (fixed_vga_enable ? 24'h030100 : 24'h038000))
    else $error("display class wrong");
  a_class_zero: assert property (
    @(posedge core_clk) disable iff (!rst_int_b)
    zero_base_class_select |-> function_class_value ==
    (fixed_vga_enable ? 24'h000100 : 24'h000000))
    else $error("zero class wrong");
  a_write_take: assert property (
    @(posedge core_clk) disable iff (!rst_int_b)
    cmd_wr_hit && cfg_be[0] |=>
    pci_bus_command[2:0] == $past(cfg_wdata[2:0]))
    else $error("write lost");
  a_write_keep: assert property (
    @(posedge core_clk) disable iff (!rst_int_b)
    !(cmd_wr_hit && cfg_be[0]) |=> $stable(pci_bus_command))
    else $error("command changed without write");
  a_cmd_read: assert property (
    @(posedge core_clk) disable iff (!rst_int_b)
    cmd_rd_hit |=> cfg_rdata == {16'h0000, $past(pci_bus_command)})
    else $error("command read wrong");
  a_class_read: assert property (
    @(posedge core_clk) disable iff (!rst_int_b)
    class_rd_hit |=> cfg_rdata == {$past(function_class_value), 8'h00})
    else $error("class read wrong");
  a_other_read: assert property (
    @(posedge core_clk) disable iff (!rst_int_b)
    cfg_rd && !cmd_rd_hit && !class_rd_hit |=> cfg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (
    @(posedge core_clk) disable iff (!rst_int_b)
    !cfg_rd |=> $stable(cfg_rdata))
    else $error("read data changed without read");
endmodule
`default_nettype wire

// file: pcicc_host.sv
// Host bridge model issuing configuration reads and writes
`timescale 1ns/1ps
`default_nettype none
module pcicc_host (
  input wire logic core_clk, // Bus clock
  output logic cfg_sel, // Config cycle to device
  output logic cfg_wr, // 1 write
  output pcicc_pkg::pcicc_dword_t cfg_dword, // Dword index
  output pcicc_pkg::pcicc_be_t cfg_be, // Byte enables
  output pcicc_pkg::pcicc_data_t cfg_wdata // Write data
);
  import pcicc_pkg::*;
  initial {cfg_sel, cfg_wr, cfg_dword, cfg_be, cfg_wdata} = '0;
  // Whole cycle held up to the taking edge, aimed by dword
  task automatic access(input logic w, input pcicc_dword_t d,
    input pcicc_be_t b, input pcicc_data_t v);
    @(posedge core_clk);
    {cfg_sel, cfg_wr, cfg_dword, cfg_be, cfg_wdata} <= {1'h1, w, d, b, v};
    @(posedge core_clk);
    cfg_sel <= 1'h0;
    cfg_be <= 4'h0;
    cfg_wdata <= ~v; // Released lines must not keep the old value
    #1;
  endtask
endmodule
`default_nettype wire

// file: tb_pci_config_command_class.sv
// Self-checking bench for the command and class code block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] %0t got %0h exp %0h", $time, a, b); end end
module tb_pci_config_command_class;
  import pcicc_pkg::*;
  logic core_clk = 1'h0, rst_b = 1'h0;
  logic zero_base_class_select = 1'h0, fixed_vga_enable = 1'h0;
  logic io_hit = 1'h0, mem_hit = 1'h0, palette_wr = 1'h0, master_req = 1'h0;
  logic cfg_sel, cfg_wr, io_claim, mem_claim, palette_snoop, master_start;
  logic special_claim, mwi_issue;
  pcicc_dword_t cfg_dword;
  pcicc_be_t cfg_be, be;
  pcicc_data_t cfg_wdata, wd;
  logic [31:0] cfg_rdata;
  logic [15:0] pci_bus_command, exp_cmd;
  logic [23:0] function_class_value;
  int n_errors = 0, n_compared = 0;
  always #12.5 core_clk = ~core_clk;
  pcicc_host pcicc_host_i (.core_clk, .cfg_sel, .cfg_wr, .cfg_dword,
    .cfg_be, .cfg_wdata);
  pcicc_cfg pcicc_cfg_i (.core_clk, .rst_b, .zero_base_class_select,
    .fixed_vga_enable, .cfg_sel, .cfg_wr, .cfg_dword, .cfg_be, .cfg_wdata,
    .cfg_rdata, .io_hit, .mem_hit, .palette_wr, .master_req, .io_claim,
    .mem_claim, .palette_snoop, .master_start, .special_claim, .mwi_issue,
    .pci_bus_command, .function_class_value);
  function automatic logic [23:0] exp_class(input logic z, v);
    return {z ? 8'h00 : 8'h03, v ? 8'h01 : (z ? 8'h00 : 8'h80), 8'h00};
  endfunction
  task automatic hits();
    @(posedge core_clk);
    {io_hit, mem_hit, palette_wr, master_req} <= 4'($urandom);
    #1;
    `CHK(io_claim, io_hit & exp_cmd[0])
    `CHK(mem_claim, mem_hit & exp_cmd[1])
    `CHK(master_start, master_req & exp_cmd[2])
    `CHK(palette_snoop, palette_wr & exp_cmd[5])
    `CHK({special_claim, mwi_issue}, 2'h0)
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #50000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(59));
    for (int k = 0; k < 4; k++) begin
      @(posedge core_clk);
      {zero_base_class_select, fixed_vga_enable} <= 2'(k);
      rst_b <= 1'h0;
      repeat (6) @(posedge core_clk);
      rst_b <= 1'h1;
      repeat (3) @(posedge core_clk);
      #1;
      exp_cmd = 16'h0000;
      `CHK(pci_bus_command, exp_cmd)
      `CHK(function_class_value, exp_class(k[1], k[0]))
      pcicc_host_i.access(1'h0, 6'h02, 4'hF, 32'h0);
      `CHK(cfg_rdata, {exp_class(k[1], k[0]), 8'h00})
    end
    $display("class code test done");
    for (int i = 0; i < 30; i++) begin
      wd = (i == 0) ? 32'hFFFFFFFF : (i == 29) ? 32'h0 : $urandom;
      be = (i == 0 || i == 29) ? 4'hF : 4'($urandom);
      if (be[0]) exp_cmd = {8'h00, wd[7:0] & 8'h27};
      pcicc_host_i.access(1'h1, 6'h01, be, wd);
      pcicc_host_i.access(1'h1, 6'h03, 4'hF, ~wd);
      `CHK(pci_bus_command, exp_cmd)
      pcicc_host_i.access(1'h0, 6'h01, 4'hF, 32'h0);
      `CHK(cfg_rdata, {16'h0000, exp_cmd})
      hits();
    end
    pcicc_host_i.access(1'h0, 6'h02, 4'hF, 32'h0);
    `CHK(cfg_rdata, {exp_class(1'h1, 1'h1), 8'h00})
    pcicc_host_i.access(1'h0, 6'h05, 4'hF, 32'h0);
    `CHK(cfg_rdata, 32'h0)
    $display("command test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
